// ===== hw/ufc_byte_fifo.v
// Purpose: 16-byte fifo with clear, used for both tx and rx paths
// Assumes: single clock, synchronous active-high reset
// Notes:   writes when full are dropped; reads when empty are ignored
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defines.vh"

module ufc_byte_fifo
(
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  clear,
  input  wire                  wr_en,
  input  wire [7:0]            wr_data,
  input  wire                  rd_en,
  output wire [7:0]            rd_data,
  output reg  [`UFC_CNT_W-1:0] count
);

  reg [7:0]            mem [0:`UFC_FIFO_DEPTH-1];
  reg [`UFC_PTR_W-1:0] wr_ptr;
  reg [`UFC_PTR_W-1:0] rd_ptr;
  wire                 full;
  wire                 empty;
  wire                 do_wr;
  wire                 do_rd;

  assign full    = (count == `UFC_FIFO_DEPTH);
  assign empty   = (count == {`UFC_CNT_W{1'b0}});
  assign do_wr   = wr_en && !full;
  assign do_rd   = rd_en && !empty;
  assign rd_data = mem[rd_ptr];

  always @(posedge clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= wr_data;
    end
  end

  // clear resets pointers and count; storage left as is, unreachable anyway
  always @(posedge clk)
  begin
    if (rst || clear)
    begin
      wr_ptr <= {`UFC_PTR_W{1'b0}};
      rd_ptr <= {`UFC_PTR_W{1'b0}};
      count  <= {`UFC_CNT_W{1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count <= count + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/ufc_defines.vh
// Purpose: constants for the uart fifo control and dma ready block
// Assumes: 16-deep byte fifos, 8-bit control register
// Notes:   bit positions of the fifo control register and trigger levels
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

`define UFC_FIFO_DEPTH      16
`define UFC_PTR_W           4
`define UFC_CNT_W           5
`define UFC_CTL_RESET       8'h00
`define UFC_BIT_FIFO_EN     0
`define UFC_BIT_RX_CLEAR    1
`define UFC_BIT_TX_CLEAR    2
`define UFC_BIT_DMA_MODE    3
`define UFC_TRIG_HI         7
`define UFC_TRIG_LO         6
`define UFC_TRIG_LVL_00     5'h01
`define UFC_TRIG_LVL_01     5'h04
`define UFC_TRIG_LVL_10     5'h08
`define UFC_TRIG_LVL_11     5'h0E
`define UFC_CTL_KEEP_MASK   8'hC9

`endif

// ===== hw/ufc_dma_ready.v
// Purpose: dma ready pin generation for transmit and receive
// Assumes: counts and flags come from the same clock domain
// Notes:   outputs are registered, active low
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defines.vh"

module ufc_dma_ready
(
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  fifo_en,
  input  wire                  dma_mode,
  input  wire [`UFC_CNT_W-1:0] tx_count,
  input  wire                  tx_hold_full,
  input  wire                  tx_load,
  input  wire [`UFC_CNT_W-1:0] rx_count,
  input  wire                  rx_hold_full,
  input  wire                  rx_trig_hit,
  input  wire                  rx_timeout,
  output reg                   tx_dma_ready_n,
  output reg                   rx_dma_ready_n
);

  wire block_mode;
  wire tx_none;
  wire rx_none;
  reg  next_tx;
  reg  next_rx;

  assign block_mode = fifo_en && dma_mode;
  assign tx_none    = fifo_en ? (tx_count == {`UFC_CNT_W{1'b0}}) : !tx_hold_full;
  assign rx_none    = fifo_en ? (rx_count == {`UFC_CNT_W{1'b0}}) : !rx_hold_full;

  always @*
  begin
    next_tx = tx_dma_ready_n;
    next_rx = rx_dma_ready_n;
    if (block_mode)
    begin
      if (tx_count == `UFC_FIFO_DEPTH)
      begin
        next_tx = 1'b1; // RULE9
      end
      else if (tx_count == {`UFC_CNT_W{1'b0}})
      begin
        next_tx = 1'b0; // RULE9
      end
      // between full and empty the level is held
      // RULE10
      if (rx_trig_hit || rx_timeout)
      begin
        next_rx = 1'b0; // RULE11
      end
      else if (rx_count == {`UFC_CNT_W{1'b0}})
      begin
        next_rx = 1'b1; // RULE12
      end
    end
    else
    begin
      // a load wins so the pin rises on the first character written
      next_tx = !(tx_none && !tx_load); // RULE5 RULE6
      next_rx = rx_none;                // RULE7 RULE8
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_dma_ready_n <= 1'b0;
      rx_dma_ready_n <= 1'b1;
    end
    else
    begin
      tx_dma_ready_n <= next_tx;
      rx_dma_ready_n <= next_rx;
    end
  end

endmodule
`default_nettype wire

// ===== hw/ufc_top.v
// Purpose: fifo control of a uart: enable, clears, rx trigger, dma ready pins
// Assumes: host writes fifo_control via a one-cycle strobe; serial side
//          hands characters in and takes them out with one-cycle strobes
// Notes:   disabled fifos behave as one-character holding registers
//
// Overview of operation
// RULE1 - rx interrupt when count equals trigger level
// RULE2 - rx fifo keeps filling until full
// RULE3 - trigger field selects 1, 4, 8, 14
// RULE4 - control bit 3 selects dma mode
// RULE5 - mode 0: tx ready low when nothing held
// RULE6 - mode 0: tx ready high on first write
// RULE7 - mode 0: rx ready low while data waits
// RULE8 - mode 0: rx ready high when drained
// RULE9 - mode 1: tx ready high full, low empty
// RULE10 - mode 1: tx ready holds when partly filled
// RULE11 - mode 1: rx ready low on trigger/timeout
// RULE12 - mode 1: rx ready high when rx empty
// RULE13 - bit 2 clears tx fifo, self-clears
// RULE14 - bit 1 clears rx fifo, self-clears
// RULE15 - bit 0 enables both fifos, default off
// RULE16 - writes with bit 0 low ignore others
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defines.vh"

module ufc_top
(
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  ctl_wr,
  input  wire [7:0]            ctl_wdata,
  output reg  [7:0]            fifo_control,
  input  wire                  tx_wr,
  input  wire [7:0]            tx_wdata,
  input  wire                  tx_pop,
  output reg  [7:0]            tx_char,
  output reg                   tx_avail,
  input  wire                  rx_push,
  input  wire [7:0]            rx_wdata,
  input  wire                  rx_rd,
  output reg  [7:0]            rx_char,
  output reg                   rx_avail,
  input  wire                  rx_timeout,
  output reg                   rx_trigger_irq,
  output reg                   tx_dma_ready_n,
  output reg                   rx_dma_ready_n,
  output reg  [`UFC_CNT_W-1:0] tx_level,
  output reg  [`UFC_CNT_W-1:0] rx_level
);

  reg                   fifo_en;
  reg                   dma_mode;
  reg  [1:0]            rx_trigger_level;
  reg                   tx_fifo_clear;
  reg                   rx_fifo_clear;
  reg  [7:0]            tx_holding_reg;
  reg                   tx_hold_full;
  reg  [7:0]            rx_hold;
  reg                   rx_hold_full;
  reg                   trig_seen;
  wire [`UFC_CNT_W-1:0] tx_count;
  wire [`UFC_CNT_W-1:0] rx_count;
  wire [7:0]            tx_fifo_out;
  wire [7:0]            rx_fifo_out;
  wire [`UFC_CNT_W-1:0] trig_lvl;
  wire                  trig_hit;
  wire                  en_write;
  wire                  mode_change;
  wire                  tx_ready_n_w;
  wire                  rx_ready_n_w;

  function [`UFC_CNT_W-1:0] trig_decode;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   trig_decode = `UFC_TRIG_LVL_00;
        2'b01:   trig_decode = `UFC_TRIG_LVL_01;
        2'b10:   trig_decode = `UFC_TRIG_LVL_10;
        default: trig_decode = `UFC_TRIG_LVL_11;
      endcase
    end
  endfunction

  function is_empty;
    input [`UFC_CNT_W-1:0] cnt;
    begin
      is_empty = (cnt == {`UFC_CNT_W{1'b0}});
    end
  endfunction

  assign en_write    = ctl_wr && ctl_wdata[`UFC_BIT_FIFO_EN];
  // toggling fifo mode discards queued data in both directions
  assign mode_change = ctl_wr && (ctl_wdata[`UFC_BIT_FIFO_EN] != fifo_en);
  assign trig_lvl    = trig_decode(rx_trigger_level); // RULE3
  assign trig_hit    = fifo_en && (rx_count == trig_lvl); // RULE1

  // control register; clear bits are one-cycle pulses
  always @(posedge clk)
  begin
    if (rst)
    begin
      fifo_en          <= 1'b0; // RULE15
      dma_mode         <= 1'b0; // RULE4
      rx_trigger_level <= 2'b00;
      tx_fifo_clear    <= 1'b0;
      rx_fifo_clear    <= 1'b0;
    end
    else
    begin
      tx_fifo_clear <= 1'b0; // RULE13
      rx_fifo_clear <= 1'b0; // RULE14
      if (ctl_wr)
      begin
        fifo_en <= ctl_wdata[`UFC_BIT_FIFO_EN]; // RULE15
      end
      if (en_write) // RULE16
      begin
        dma_mode         <= ctl_wdata[`UFC_BIT_DMA_MODE]; // RULE4
        rx_trigger_level <= ctl_wdata[`UFC_TRIG_HI:`UFC_TRIG_LO];
        tx_fifo_clear    <= ctl_wdata[`UFC_BIT_TX_CLEAR] || mode_change; // RULE13
        rx_fifo_clear    <= ctl_wdata[`UFC_BIT_RX_CLEAR] || mode_change; // RULE14
      end
      else if (mode_change)
      begin
        tx_fifo_clear <= 1'b1;
        rx_fifo_clear <= 1'b1;
      end
    end
  end

  ufc_byte_fifo u_tx_fifo
  (
    .clk     (clk),
    .rst     (rst),
    .clear   (tx_fifo_clear),
    .wr_en   (tx_wr && fifo_en),
    .wr_data (tx_wdata),
    .rd_en   (tx_pop && fifo_en),
    .rd_data (tx_fifo_out),
    .count   (tx_count)
  );

  // rx keeps accepting past the trigger level up to full
  ufc_byte_fifo u_rx_fifo
  (
    .clk     (clk),
    .rst     (rst),
    .clear   (rx_fifo_clear),
    .wr_en   (rx_push && fifo_en), // RULE2
    .wr_data (rx_wdata),
    .rd_en   (rx_rd && fifo_en),
    .rd_data (rx_fifo_out),
    .count   (rx_count)
  );

  // single-character holding registers used when fifos are off;
  // clears do not touch the shift registers, which live outside
  always @(posedge clk)
  begin
    if (rst || tx_fifo_clear)
    begin
      tx_holding_reg <= 8'h00;
      tx_hold_full   <= 1'b0;
    end
    else if (!fifo_en)
    begin
      if (tx_wr && !tx_hold_full)
      begin
        tx_holding_reg <= tx_wdata;
        tx_hold_full   <= 1'b1;
      end
      else if (tx_pop)
      begin
        tx_hold_full <= 1'b0;
      end
    end
  end

  always @(posedge clk)
  begin
    if (rst || rx_fifo_clear)
    begin
      rx_hold      <= 8'h00;
      rx_hold_full <= 1'b0;
    end
    else if (!fifo_en)
    begin
      if (rx_push)
      begin
        // overrun: newest character replaces the old one
        rx_hold      <= rx_wdata;
        rx_hold_full <= 1'b1;
      end
      else if (rx_rd)
      begin
        rx_hold_full <= 1'b0;
      end
    end
  end

  ufc_dma_ready u_dma
  (
    .clk            (clk),
    .rst            (rst),
    .fifo_en        (fifo_en),
    .dma_mode       (dma_mode),
    .tx_count       (tx_count),
    .tx_hold_full   (tx_hold_full),
    .tx_load        (tx_wr), // RULE6
    .rx_count       (rx_count),
    .rx_hold_full   (rx_hold_full),
    .rx_trig_hit    (trig_hit), // RULE11
    .rx_timeout     (rx_timeout && fifo_en),
    .tx_dma_ready_n (tx_ready_n_w),
    .rx_dma_ready_n (rx_ready_n_w)
  );

  // irq fires on reaching the level and clears once below it
  always @(posedge clk)
  begin
    if (rst)
    begin
      trig_seen <= 1'b0;
    end
    else if (!fifo_en || rx_count < trig_lvl)
    begin
      trig_seen <= 1'b0;
    end
    // a level lowered under a fuller fifo still raises the irq
    else
    begin
      trig_seen <= 1'b1; // RULE1
    end
  end

  // host readback; clear bits are masked so they always read 0
  always @(posedge clk)
  begin
    if (rst)
    begin
      fifo_control   <= `UFC_CTL_RESET;
      rx_trigger_irq <= 1'b0;
    end
    else
    begin
      fifo_control   <= {rx_trigger_level, 2'b00, dma_mode, tx_fifo_clear,
                         rx_fifo_clear, fifo_en} & `UFC_CTL_KEEP_MASK;
      rx_trigger_irq <= trig_hit || trig_seen; // RULE1
    end
  end

  // registered data view for the serial side and the host
  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_char  <= 8'h00;
      tx_avail <= 1'b0;
      rx_char  <= 8'h00;
      rx_avail <= 1'b0;
    end
    else
    begin
      tx_char  <= fifo_en ? tx_fifo_out : tx_holding_reg;
      tx_avail <= fifo_en ? !is_empty(tx_count) : tx_hold_full;
      rx_char  <= fifo_en ? rx_fifo_out : rx_hold;
      rx_avail <= fifo_en ? !is_empty(rx_count) : rx_hold_full;
    end
  end

  // fill levels, one cycle behind the fifo counters
  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_level <= {`UFC_CNT_W{1'b0}};
      rx_level <= {`UFC_CNT_W{1'b0}};
    end
    else
    begin
      tx_level <= tx_count;
      rx_level <= rx_count;
    end
  end

  // re-registered pins: one more cycle of latency buys clean outputs
  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_dma_ready_n <= 1'b0;
      rx_dma_ready_n <= 1'b1;
    end
    else
    begin
      tx_dma_ready_n <= tx_ready_n_w;
      rx_dma_ready_n <= rx_ready_n_w;
    end
  end

endmodule
`default_nettype wire

// ===== test/ufc_dma_model.sv
// Purpose: dma controller model serving the ready pins
// Assumes: one request pulse per cycle the pin is seen low while slow is off
// Notes:   overshoots by the pin latency, as a real one would
`timescale 1ns/1ps
`default_nettype none
module ufc_dma_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tx_go,
  input  wire logic       rx_go,
  input  wire logic       slow,
  input  wire logic       tx_dma_ready_n,
  input  wire logic       rx_dma_ready_n,
  output var  logic       tx_wr,
  output var  logic [7:0] tx_wdata,
  output var  logic       rx_rd
);
  logic gap;
  initial {gap, tx_wr, tx_wdata, rx_rd} = {2'b00, 8'hA5, 1'b0};
  // slow mode leaves a gap cycle after each request
  always @(posedge clk)
  begin
    gap      <= slow && !gap;
    tx_wr    <= !rst && tx_go && !gap && !tx_dma_ready_n;
    rx_rd    <= !rst && rx_go && !gap && !rx_dma_ready_n;
    // data advances only after a write, so the first byte sent is A5
    if (tx_wr)
    begin
      tx_wdata <= tx_wdata + 8'h5B;
    end
  end
endmodule
`default_nettype wire

// ===== test/ufc_props.sv
// Purpose: port assertions for the fifo control block
// Assumes: one clock, sync active-high reset
// Notes:   4-cycle quiet windows absorb the 2-edge pin latency
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defines.vh"
module ufc_props
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  ctl_wr,
  input wire logic [7:0]            fifo_control,
  input wire logic                  tx_wr,
  input wire logic                  tx_pop,
  input wire logic                  tx_avail,
  input wire logic                  rx_push,
  input wire logic                  rx_rd,
  input wire logic                  rx_avail,
  input wire logic                  rx_timeout,
  input wire logic                  rx_trigger_irq,
  input wire logic                  tx_dma_ready_n,
  input wire logic                  rx_dma_ready_n,
  input wire logic [`UFC_CNT_W-1:0] tx_level,
  input wire logic [`UFC_CNT_W-1:0] rx_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire       quiet = !ctl_wr;
  wire       m1    = fifo_control[0] && fifo_control[3];
  wire [4:0] lvl   = fifo_control[7] ? (fifo_control[6] ? 5'h0E : 5'h08)
                                     : (fifo_control[6] ? 5'h04 : 5'h01);
  sequence hold4(c);
    (c) [*4];
  endsequence
  tx_empty_low_a: assert property (hold4(quiet && !tx_wr && !tx_avail && tx_level == 5'h00)
    |-> !tx_dma_ready_n) else $error("tx ready not low when empty");
  tx_full_high_a: assert property (hold4(quiet && m1 && !tx_pop && tx_level == 5'h10)
    |-> tx_dma_ready_n) else $error("tx ready not high when full");
  tx_ready_hold_a: assert property (hold4(quiet && m1 && tx_level != 5'h00
    && tx_level != 5'h10) |-> $stable(tx_dma_ready_n)) else $error("tx ready moved");
  rx_wait_low_a: assert property (hold4(quiet && !m1 && !rx_rd && rx_avail)
    |-> !rx_dma_ready_n) else $error("rx ready not low with data");
  rx_empty_high_a: assert property (hold4(quiet && !rx_push && !rx_timeout
    && !rx_avail && rx_level == 5'h00) |-> rx_dma_ready_n) else $error("rx ready not high");
  rx_trig_low_a: assert property (hold4(quiet && m1 && rx_trigger_irq)
    |-> !rx_dma_ready_n) else $error("rx ready not low at trigger");
  irq_set_a: assert property (hold4(quiet && fifo_control[0] && rx_level >= lvl)
    |-> rx_trigger_irq) else $error("trigger irq missing");
  irq_clear_a: assert property (hold4(quiet && rx_level < lvl)
    |-> !rx_trigger_irq) else $error("trigger irq early");
endmodule
bind ufc_top ufc_props u_props (.clk, .rst, .ctl_wr, .fifo_control, .tx_wr, .tx_pop, .tx_avail,
  .rx_push, .rx_rd, .rx_avail, .rx_timeout, .rx_trigger_irq, .tx_dma_ready_n,
  .rx_dma_ready_n, .tx_level, .rx_level);
`default_nettype wire

// ===== test/ufc_top_tb.sv
// Purpose: self-checking bench for the fifo control block
// Assumes: dma model on the ready pins, bench plays host and shifter
// Notes:   checks sample at the falling edge, after updates land
`timescale 1ns/1ps
`default_nettype none
module ufc_top_tb;
  logic       clk = 1'b0, rst = 1'b1, ctl_wr = 1'b0, tx_pop = 1'b0, rx_push = 1'b0;
  logic       rx_timeout = 1'b0, tx_go = 1'b0, rx_go = 1'b0, slow = 1'b0;
  logic [7:0] ctl_wdata = 8'h00, rx_wdata = 8'h00, tx_wdata, fifo_control, tx_char, rx_char;
  logic       tx_wr, rx_rd, tx_avail, rx_avail, rx_trigger_irq, tx_dma_ready_n, rx_dma_ready_n;
  logic [4:0] tx_level, rx_level;
  int         fail_count = 0, checked = 0, trig[4] = '{1, 4, 8, 14};
  always #2.5 clk = ~clk;
  ufc_top u_dut (.clk, .rst, .ctl_wr, .ctl_wdata, .fifo_control, .tx_wr, .tx_wdata, .tx_pop,
    .tx_char, .tx_avail, .rx_push, .rx_wdata, .rx_rd, .rx_char, .rx_avail, .rx_timeout,
    .rx_trigger_irq, .tx_dma_ready_n, .rx_dma_ready_n, .tx_level, .rx_level);
  ufc_dma_model u_dma (.clk, .rst, .tx_go, .rx_go, .slow, .tx_dma_ready_n, .rx_dma_ready_n,
    .tx_wr, .tx_wdata, .rx_rd);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wctl(input logic [7:0] d);
    @(posedge clk);
    ctl_wr <= 1'b1;
    ctl_wdata <= d;
    @(posedge clk);
    ctl_wr <= 1'b0;
    tick(5);
  endtask
  // k: 0 rx push, 1 tx pop, 2 rx timeout
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      @(posedge clk);
      {rx_push, tx_pop, rx_timeout} <= {k == 0, k == 1, k == 2};
      rx_wdata <= rx_wdata + 8'h11;
    end
    @(posedge clk);
    {rx_push, tx_pop, rx_timeout} <= 3'b000;
    tick(6);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // far beyond the roughly 350 cycles the sequence needs
  initial
  begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("fifo_control", 8'h00, fifo_control);
    chk("tx_ready", 8'h00, 8'(tx_dma_ready_n));
    pulse(0, 3);
    chk("rx_level", 8'h00, 8'(rx_level));
    chk("rx_avail", 8'h01, 8'(rx_avail));
    chk("rx_char", 8'h33, rx_char);
    chk("rx_ready", 8'h00, 8'(rx_dma_ready_n));
    rx_go <= 1'b1;
    tick(8);
    chk("rx_ready", 8'h01, 8'(rx_dma_ready_n));
    rx_go <= 1'b0;
    foreach (trig[c])
    begin
      wctl({c[1:0], 6'h03});
      chk("fifo_control", {c[1:0], 6'h01}, fifo_control);
      chk("rx_level", 8'h00, 8'(rx_level));
      pulse(0, trig[c] - 1);
      chk("irq", 8'h00, 8'(rx_trigger_irq));
      pulse(0, 1);
      chk("irq", 8'h01, 8'(rx_trigger_irq));
    end
    pulse(0, 3);
    chk("rx_level", 8'h10, 8'(rx_level));
    wctl(8'h08);
    chk("fifo_control", 8'hC0, fifo_control);
    wctl(8'h01);
    chk("tx_ready", 8'h00, 8'(tx_dma_ready_n));
    tx_go <= 1'b1;
    tick(6);
    tx_go <= 1'b0;
    chk("tx_ready", 8'h01, 8'(tx_dma_ready_n));
    chk("tx_char", 8'hA5, tx_char);
    pulse(1, 5);
    chk("tx_ready", 8'h00, 8'(tx_dma_ready_n));
    chk("tx_avail", 8'h00, 8'(tx_avail));
    wctl(8'h09);
    chk("fifo_control", 8'h09, fifo_control);
    slow <= 1'b1;
    tx_go <= 1'b1;
    repeat (80) if (tx_dma_ready_n !== 1'b1) @(negedge clk);
    tx_go <= 1'b0;
    tick(4);
    chk("tx_level", 8'h10, 8'(tx_level));
    pulse(1, 15);
    chk("tx_ready", 8'h01, 8'(tx_dma_ready_n));
    wctl(8'h0D);
    chk("tx_level", 8'h00, 8'(tx_level));
    chk("tx_ready", 8'h00, 8'(tx_dma_ready_n));
    wctl(8'h49);
    pulse(0, 3);
    chk("rx_ready", 8'h01, 8'(rx_dma_ready_n));
    pulse(0, 1);
    chk("rx_ready", 8'h00, 8'(rx_dma_ready_n));
    rx_go <= 1'b1;
    tick(20);
    chk("rx_ready", 8'h01, 8'(rx_dma_ready_n));
    rx_go <= 1'b0;
    pulse(0, 1);
    pulse(2, 1);
    chk("rx_ready", 8'h00, 8'(rx_dma_ready_n));
    rx_go <= 1'b1;
    tick(8);
    chk("rx_level", 8'h00, 8'(rx_level));
    chk("rx_ready", 8'h01, 8'(rx_dma_ready_n));
    tally_and_finish;
  end
endmodule
`default_nettype wire
